// file: cma_pkg.sv
package cma_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV_TRANS = 7'h02,
    ST_DEV_ACC = 7'h04,
    ST_DEV_TRANS_PEND = 7'h08,
    ST_DEV_ACC_PEND = 7'h10,
    ST_CPU_ACC1 = 7'h20,
    ST_CPU_ACC2 = 7'h40
  } cma_state_t;

  typedef struct packed {
    logic device_mem_request;
    logic device_burst_request;
    logic device_cycle_begin;
  } cma_dev_req_t;

  typedef struct packed {
    logic cpu_mem_request;
    logic cpu_last_access;
    logic cpu_write;
  } cma_cpu_req_t;

  typedef struct packed {
    logic sram_chip_select_n;
    logic sram_write_n;
    logic sram_output_enable_n;
    logic owner_is_cpu;
  } cma_sram_ctl_t;

  localparam int SYNC_STAGES = 2;
  localparam logic [0:0] SYNC_RESET = 1'h0;
  // All strobes high (inactive) and the memory owned by nobody.
  localparam cma_sram_ctl_t SRAM_CTL_IDLE = 4'hE;
endpackage

// file: cma_sync.sv
`timescale 1ns/1ps
module cma_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import cma_pkg::*;
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_reg <= {WIDTH{SYNC_RESET}};
      stage2_reg <= {WIDTH{SYNC_RESET}};
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// file: cma_arbiter.sv
`timescale 1ns/1ps
module cma_arbiter (
  input wire logic clock,
  input wire logic rst_n,
  input wire cma_pkg::cma_dev_req_t dev_req,
  input wire cma_pkg::cma_cpu_req_t cpu_req,
  output logic device_mem_grant,
  output logic cpu_mem_ready,
  output cma_pkg::cma_sram_ctl_t sram_ctl
);
  import cma_pkg::*;

  // Both parties run on their own clocks as far as this block knows, so all
  // request inputs pass a two-stage synchroniser; this adds latency.
  logic [5:0] sync_in;
  logic [5:0] sync_out;
  cma_dev_req_t dev_s;
  cma_cpu_req_t cpu_s;

  assign sync_in = {dev_req, cpu_req};

  cma_sync #(
    .WIDTH(6)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign dev_s = sync_out[5:3];
  assign cpu_s = sync_out[2:0];

  cma_state_t state_reg;
  cma_state_t state_next;
  logic grant_reg;
  logic grant_next;
  logic ready_reg;
  logic ready_next;
  cma_sram_ctl_t ctl_reg;
  cma_sram_ctl_t ctl_next;
  logic dev_active;
  logic cpu_hold_reg;
  logic cpu_hold_next;
  logic cpu_pending;

  assign dev_active = dev_s.device_cycle_begin | dev_s.device_burst_request;

  // The synchroniser shows a dropped processor request two cycles late.
  // Without this hold the finished request would look new once back in
  // idle and the processor would be served twice. The hold is released
  // only once the request has been seen low.
  always_comb begin
    cpu_hold_next = cpu_hold_reg;
    if (state_reg == ST_CPU_ACC2 && cpu_s.cpu_last_access) begin
      cpu_hold_next = 1'h1;
    end else if (!cpu_s.cpu_mem_request) begin
      cpu_hold_next = 1'h0;
    end
  end

  assign cpu_pending = cpu_s.cpu_mem_request && !cpu_hold_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (dev_s.device_mem_request && cpu_pending) begin
          state_next = ST_DEV_TRANS_PEND;
        end else if (dev_s.device_mem_request) begin
          state_next = ST_DEV_TRANS;
        end else if (cpu_pending) begin
          state_next = ST_CPU_ACC1;
        end
      end
      // The cycle begin of the device reaches the state machine through the
      // synchroniser, so the transition states wait until it is seen.
      ST_DEV_TRANS: begin
        if (dev_active) begin
          state_next = cpu_pending ? ST_DEV_ACC_PEND : ST_DEV_ACC;
        end else if (cpu_pending) begin
          state_next = ST_DEV_TRANS_PEND;
        end
      end
      ST_DEV_TRANS_PEND: begin
        if (dev_active) begin
          state_next = ST_DEV_ACC_PEND;
        end
      end
      ST_DEV_ACC: begin
        if (cpu_pending) begin
          state_next = dev_active ? ST_DEV_ACC_PEND : ST_CPU_ACC1;
        end else if (!dev_active) begin
          state_next = ST_IDLE;
        end
      end
      ST_DEV_ACC_PEND: begin
        if (!dev_active) begin
          state_next = ST_CPU_ACC1;
        end
      end
      ST_CPU_ACC1: begin
        state_next = ST_CPU_ACC2;
      end
      ST_CPU_ACC2: begin
        if (dev_s.device_mem_request) begin
          state_next = (cpu_s.cpu_mem_request && !cpu_s.cpu_last_access) ?
                       ST_DEV_TRANS_PEND : ST_DEV_TRANS;
        end else if (cpu_s.cpu_last_access || !cpu_s.cpu_mem_request) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_CPU_ACC1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    grant_next = (state_next == ST_DEV_TRANS) ||
                 (state_next == ST_DEV_TRANS_PEND) ||
                 (state_next == ST_DEV_ACC) ||
                 (state_next == ST_DEV_ACC_PEND);
    ready_next = (state_next == ST_CPU_ACC2);
    // The write strobe is asserted only during the access cycle, not in the
    // address cycle before it, which gives non-early write timing.
    ctl_next.owner_is_cpu = (state_next == ST_CPU_ACC1) ||
                            (state_next == ST_CPU_ACC2);
    ctl_next.sram_chip_select_n = !((state_next == ST_DEV_ACC) ||
                                    (state_next == ST_DEV_ACC_PEND) ||
                                    (state_next == ST_CPU_ACC2));
    ctl_next.sram_write_n = !((state_next == ST_CPU_ACC2) &&
                              cpu_s.cpu_write);
    ctl_next.sram_output_enable_n = !((state_next == ST_CPU_ACC2) &&
                                      !cpu_s.cpu_write);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      grant_reg <= 1'h0;
      ready_reg <= 1'h0;
      ctl_reg <= SRAM_CTL_IDLE;
      cpu_hold_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      cpu_hold_reg <= cpu_hold_next;
      grant_reg <= grant_next;
      ready_reg <= ready_next;
      ctl_reg <= ctl_next;
    end
  end

  assign device_mem_grant = grant_reg;
  assign cpu_mem_ready = ready_reg;
  assign sram_ctl = ctl_reg;

  a_no_double_own: assert property (@(posedge clock) disable iff (!rst_n)
    !(device_mem_grant && sram_ctl.owner_is_cpu))
    else $error("both parties own control memory");
  a_device_first: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_IDLE && dev_s.device_mem_request &&
     cpu_pending) |=> state_reg == ST_DEV_TRANS_PEND)
    else $error("device not given priority");
  a_trans_grant: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_IDLE && dev_s.device_mem_request &&
     !cpu_pending) |=> device_mem_grant)
    else $error("device grant missing after request");
  a_trans_wait: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_DEV_TRANS && !dev_active && !cpu_pending)
    |=> state_reg == ST_DEV_TRANS)
    else $error("transition left before cycle begin");
  a_dev_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_DEV_ACC && !cpu_pending && dev_active)
    |=> state_reg == ST_DEV_ACC)
    else $error("device access left early");
  a_pend_trans: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_DEV_TRANS_PEND && dev_active)
    |=> state_reg == ST_DEV_ACC_PEND)
    else $error("pending transition broken");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_IDLE |->
    sram_ctl.sram_chip_select_n && !device_mem_grant)
    else $error("memory strobed while idle");
  a_pend_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_DEV_ACC_PEND && !dev_active) |=> ##1
    sram_ctl.owner_is_cpu)
    else $error("pending cpu request lost");
  a_cpu_two: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_CPU_ACC1 |=> state_reg == ST_CPU_ACC2)
    else $error("cpu access not two states");
  a_write_one: assert property (@(posedge clock) disable iff (!rst_n)
    !sram_ctl.sram_write_n |=> sram_ctl.sram_write_n)
    else $error("write strobe longer than one cycle");
  a_ready_end: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(sram_ctl.owner_is_cpu) |=> cpu_mem_ready)
    else $error("ready not at end of cpu access");
  a_ready_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    cpu_mem_ready |=> !cpu_mem_ready)
    else $error("ready held longer than one cycle");
  a_hold_block: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_IDLE && cpu_hold_reg && !dev_s.device_mem_request)
    |=> !sram_ctl.owner_is_cpu)
    else $error("finished cpu request served again");

  c_dev_only: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_DEV_TRANS ##1 state_reg == ST_DEV_ACC);
  c_both: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_DEV_ACC_PEND ##1 state_reg == ST_CPU_ACC1);
  c_cpu_only: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_IDLE ##1 state_reg == ST_CPU_ACC1);
  c_burst: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == ST_DEV_ACC && dev_s.device_burst_request);
endmodule

// file: cma_party.sv
`timescale 1ns/1ps
module cma_party (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic device_mem_grant,
  input wire logic cpu_mem_ready,
  input wire logic dev_go,
  input wire logic cpu_go,
  input wire logic cpu_wr,
  input wire logic [3:0] dev_len,
  output cma_pkg::cma_dev_req_t dev_req,
  output cma_pkg::cma_cpu_req_t cpu_req
);
  import cma_pkg::*;
  logic dg, cg;
  logic [3:0] left;
  initial begin
    dev_req = '0;
    cpu_req = '0;
  end
  // Go strobes are taken at the edge so the bench may change them at +2.
  always @(posedge clock) begin
    dg = dev_go;
    cg = cpu_go;
    #2;
    if (!rst_n) begin
      dev_req = '0;
      cpu_req = '0;
    end else begin
      if (dg) dev_req.device_mem_request = 1'b1;
      if (dev_req.device_cycle_begin) begin
        if (left == 4'h0) dev_req = '0;
        left = left - 4'h1;
      end else if (device_mem_grant && dev_req.device_mem_request) begin
        dev_req.device_cycle_begin = 1'b1;
        dev_req.device_burst_request = dev_len[3];
        left = dev_len;
      end
      if (cg) cpu_req = {2'h3, cpu_wr};
      if (cpu_mem_ready) cpu_req = '0;
    end
  end
endmodule

// file: control_memory_arbiter_tb_top.sv
`timescale 1ns/1ps
module control_memory_arbiter_tb_top;
  import cma_pkg::*;
  logic clock, rst_n, dev_go, cpu_go, cpu_wr;
  logic [3:0] dev_len;
  logic device_mem_grant, cpu_mem_ready;
  cma_dev_req_t dev_req;
  cma_cpu_req_t cpu_req;
  cma_sram_ctl_t sram_ctl;
  logic [31:0] seed;
  int num_errors, checked, cyc, t_rise, t_fall, t_rdy, t0, spin;
  cma_arbiter dut_u (.clock(clock), .rst_n(rst_n), .dev_req(dev_req),
    .cpu_req(cpu_req), .device_mem_grant(device_mem_grant),
    .cpu_mem_ready(cpu_mem_ready), .sram_ctl(sram_ctl));
  cma_party party_u (.clock(clock), .rst_n(rst_n),
    .device_mem_grant(device_mem_grant), .cpu_mem_ready(cpu_mem_ready),
    .dev_go(dev_go), .cpu_go(cpu_go), .cpu_wr(cpu_wr), .dev_len(dev_len),
    .dev_req(dev_req), .cpu_req(cpu_req));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected {write, output enable}: only the strobe of the access is low.
  function automatic logic [1:0] exp_strobe(input logic wr);
    return wr ? 2'h1 : 2'h2;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run_op(input int mode);
    t0 = cyc;
    t_rdy = 0;
    @(posedge clock) #2;
    dev_go = mode != 1;
    cpu_go = mode != 0;
    @(posedge clock) #2;
    dev_go = 0;
    cpu_go = 0;
    spin = 0;
    while (spin < 80 && (spin < 6 || sram_ctl !== 4'hE || device_mem_grant
        || dev_req || cpu_req)) begin
      @(posedge clock) #2;
      spin++;
    end
    chk(spin < 80, 1'b1);
    if (mode == 0) chk(t_rise > t0, 1'b1);
    if (mode != 0) chk(t_rdy > t0, 1'b1);
    if (mode == 2) chk(t_rdy > t_fall && t_fall > t0, 1'b1);
  endtask
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    #1;
    cyc++;
    if (device_mem_grant && t_rise <= t_fall) t_rise = cyc;
    if (!device_mem_grant && t_rise > t_fall) t_fall = cyc;
    if (!sram_ctl.sram_chip_select_n && !sram_ctl.owner_is_cpu)
      chk(device_mem_grant, 1'b1);
    if (cpu_mem_ready === 1'b1) begin
      chk(t_rdy == cyc - 1, 1'b0);
      chk({device_mem_grant, sram_ctl}, {2'h0, exp_strobe(cpu_wr), 1'b1});
      t_rdy = cyc;
    end
  end
  initial begin
    #(5000 * 25);
    num_errors++;
    stop_test();
  end
  initial begin
    {rst_n, dev_go, cpu_go, cpu_wr, dev_len} = '0;
    {num_errors, checked, cyc, t_rise, t_fall} = '0;
    seed = 32'hE55B08E8;
    // Two edges in reset clear the input synchronisers as well.
    repeat (2) @(posedge clock);
    #2 chk({device_mem_grant, cpu_mem_ready, sram_ctl}, 8'h0E);
    rst_n = 1'b1;
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      dev_len = (i < 2) ? 4'(i * 15) : seed[3:0];
      cpu_wr = seed[4];
      run_op(i < 2 ? 2 : int'(seed[9:8] % 3));
    end
    stop_test();
  end
endmodule
